// ===== inc/tlsh_pkg.sv
// Constants, register map and carrier types of the limit status and
// hottest-of block of a multi-channel remote temperature monitor.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package tlsh_pkg;
    localparam int NUM_CHAN = 8;
    localparam int NUM_BETA = 4;
    localparam int TEMP_W = 11;
    localparam int FRAC_W = 3;

    localparam logic [7:0] ADDR_REMOTE1_HOTTEST_FLAG_BETA = 8'h25;
    localparam logic [7:0] ADDR_EXT2_BETA = 8'h26;
    localparam logic [7:0] ADDR_EXT4_BETA = 8'h71;
    localparam logic [7:0] ADDR_EXT6_BETA = 8'h72;
    localparam logic [7:0] ADDR_HOT_HIGH = 8'h32;
    localparam logic [7:0] ADDR_HOT_LOW = 8'h33;
    localparam logic [7:0] ADDR_HOT_FLAGS = 8'h34;
    localparam logic [7:0] ADDR_UPPER = 8'h35;
    localparam logic [7:0] ADDR_LOWER = 8'h36;
    localparam logic [7:0] ADDR_CRIT = 8'h37;

    // Beta register layout, reset values and which ones take writes.
    localparam int BETA_AUTO_BIT = 3;
    localparam logic [7:0] RST_REMOTE1_HOTTEST_FLAG_BETA = 8'h08;
    localparam logic [7:0] RST_EXT2_BETA = 8'h08;
    localparam logic [7:0] RST_EXT4_BETA = 8'h08;
    localparam logic [7:0] RST_EXT6_BETA = 8'h07;
    localparam logic [NUM_BETA-1:0] BETA_WRITABLE = 4'he;
    localparam logic [2:0] BETA_CODE_MIN_008 = 3'h0;
    localparam logic [2:0] BETA_CODE_MIN_233 = 3'h6;
    localparam logic [2:0] BETA_CODE_OFF = 3'h7;

    localparam logic [7:0] RST_HOT_HIGH = 8'h80;
    localparam logic [7:0] RST_HOT_LOW = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;

    // Consecutive-count codes and their counts.
    localparam logic [2:0] CONSEC_CODE_1 = 3'h0;
    localparam logic [2:0] CONSEC_CODE_2 = 3'h1;
    localparam logic [2:0] CONSEC_CODE_3 = 3'h3;
    localparam logic [2:0] CONSEC_CODE_4 = 3'h7;
    localparam logic [2:0] ALERT_FALLBACK = 3'h1;
    localparam logic [2:0] CRIT_FALLBACK = 3'h4;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic signed [TEMP_W-1:0] temp;
        logic hi_ge;
        logic lo_lt;
        logic crit_ge;
        logic crit_below_hyst;
    } tlsh_meas_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tlsh_reg_req_t;

    typedef struct packed {
        logic high;
        logic low;
        logic crit;
    } tlsh_summary_t;

    // Maps a consecutive-count code to a count, with a per-use fallback.
    function automatic logic [2:0] tlsh_consec_need(input logic [2:0] code,
                                                    input logic [2:0] fb);
        logic [2:0] n;
        n = fb;
        if (code == CONSEC_CODE_1) n = 3'h1;
        if (code == CONSEC_CODE_2) n = 3'h2;
        if (code == CONSEC_CODE_3) n = 3'h3;
        if (code == CONSEC_CODE_4) n = 3'h4;
        return n;
    endfunction
endpackage

// ===== hdl/tlsh_chan_qual.sv
// Per-channel consecutive-measurement qualifiers for high, low and
// critical conditions. Assumes measurement strobes from same-clock logic.
`timescale 1ns/1ps
module tlsh_chan_qual (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire tlsh_pkg::tlsh_meas_t meas,
    input wire logic [2:0] alert_need,
    input wire logic [2:0] crit_need,
    output logic hi_set,
    output logic lo_set,
    output logic crit_set,
    output logic crit_clr,
    output logic hi_cond_r,
    output logic lo_cond_r
);
    import tlsh_pkg::*;
    logic [2:0] hi_cnt_r, lo_cnt_r, cr_cnt_r;
    logic [2:0] a_need_r, c_need_r;
    wire [2:0] hi_inc = hi_cnt_r + 3'h1;
    wire [2:0] lo_inc = lo_cnt_r + 3'h1;
    wire [2:0] cr_inc = cr_cnt_r + 3'h1;
    // A new count only takes hold while every queue that uses it is empty.
    wire [2:0] a_need = (hi_cnt_r == 3'h0 && lo_cnt_r == 3'h0) ?
                        alert_need : a_need_r;
    wire [2:0] c_need = (cr_cnt_r == 3'h0) ? crit_need : c_need_r;
    assign hi_set = fire && meas.hi_ge && hi_inc >= a_need;
    assign lo_set = fire && meas.lo_lt && lo_inc >= a_need;
    assign crit_set = fire && meas.crit_ge && cr_inc >= c_need;
    assign crit_clr = fire && meas.crit_below_hyst;

    // Counters step on each measurement meeting the condition and restart on a miss or once qualified.
    always_ff @(posedge clk) begin
        if (rst) begin
            hi_cnt_r <= 3'h0;
            lo_cnt_r <= 3'h0;
            cr_cnt_r <= 3'h0;
            a_need_r <= ALERT_FALLBACK;
            c_need_r <= CRIT_FALLBACK;
            hi_cond_r <= 1'b0;
            lo_cond_r <= 1'b0;
        end else if (fire) begin
            a_need_r <= a_need;
            c_need_r <= c_need;
            hi_cnt_r <= (!meas.hi_ge || hi_set) ? 3'h0 : hi_inc;
            lo_cnt_r <= (!meas.lo_lt || lo_set) ? 3'h0 : lo_inc;
            cr_cnt_r <= (!meas.crit_ge || crit_set) ? 3'h0 : cr_inc;
            hi_cond_r <= meas.hi_ge;
            lo_cond_r <= meas.lo_lt;
        end
    end
endmodule

// ===== hdl/tlsh_hottest.sv
// Latest-temperature table and hottest-of comparison with registered
// results. Assumes measurements and cycle end come from same-clock logic.
`timescale 1ns/1ps
module tlsh_hottest (
    input wire logic clk,
    input wire logic rst,
    input wire tlsh_pkg::tlsh_meas_t meas,
    input wire logic cycle_done,
    input wire logic [7:0] sel,
    output logic [7:0] hot_high_r,
    output logic [7:0] hot_low_r,
    output logic [7:0] hot_flags_r
);
    import tlsh_pkg::*;
    logic signed [TEMP_W-1:0] temp_r [NUM_CHAN];
    logic signed [TEMP_W-1:0] best;
    logic [2:0] best_idx;
    logic found;

    // Strict greater-than keeps the lower-numbered channel on a tie.
    always_comb begin
        best = '0;
        best_idx = 3'h0;
        found = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (sel[i] && (!found || temp_r[i] > best)) begin
                best = temp_r[i];
                best_idx = 3'(i);
                found = 1'b1;
            end
        end
    end

    // Store each result; publish the hottest only at the cycle end.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CHAN; i++) temp_r[i] <= '0;
            hot_high_r <= RST_HOT_HIGH;
            hot_low_r <= RST_HOT_LOW;
            hot_flags_r <= RST_FLAGS;
        end else begin
            if (meas.valid) temp_r[meas.chan] <= meas.temp;
            if (cycle_done) begin
                hot_high_r <= found ? best[TEMP_W-1:FRAC_W] :
                              RST_HOT_HIGH;
                hot_low_r <= found ? {best[FRAC_W-1:0], 5'h00} :
                             RST_HOT_LOW;
                hot_flags_r <= found ? 8'h01 << best_idx :
                               RST_FLAGS;
            end
        end
    end
endmodule

// ===== hdl/tlsh_top.sv
// Limit status, beta configuration and hottest-of result logic with
// its register port. Assumes the register engine, converter and limit
// comparators are same-clock logic; nothing here crosses a clock domain.
`timescale 1ns/1ps
module tlsh_top (
    input wire logic clk,
    input wire logic rst,
    input wire tlsh_pkg::tlsh_reg_req_t reg_req,
    output logic [7:0] reg_rdata_r,
    input wire tlsh_pkg::tlsh_meas_t meas,
    input wire logic conv_start,
    input wire logic [1:0] conv_beta_idx,
    input wire logic [tlsh_pkg::NUM_BETA-1:0][2:0] beta_detect,
    input wire logic cycle_done,
    input wire logic [7:0] hottest_sel,
    input wire logic [2:0] alert_consec_count,
    input wire logic [2:0] critical_consec_count,
    output logic [tlsh_pkg::NUM_BETA-1:0][2:0] beta_apply_r,
    output tlsh_pkg::tlsh_summary_t summary_r,
    output logic alert_n_r
);
    import tlsh_pkg::*;

    // Reset images of the four beta configuration registers.
    localparam logic [7:0] BETA_RST [NUM_BETA] = '{
        RST_REMOTE1_HOTTEST_FLAG_BETA, RST_EXT2_BETA, RST_EXT4_BETA, RST_EXT6_BETA
    };
    localparam logic [7:0] BETA_ADDR [NUM_BETA] = '{
        ADDR_REMOTE1_HOTTEST_FLAG_BETA, ADDR_EXT2_BETA, ADDR_EXT4_BETA, ADDR_EXT6_BETA
    };

    // Beta configuration state.
    logic [NUM_BETA-1:0] beta_autodetect_en_r;
    logic [NUM_BETA-1:0][2:0] beta_setting_r;

    // Per-channel limit status registers.
    logic [NUM_CHAN-1:0] chan_upper_flag_r;
    logic [NUM_CHAN-1:0] chan_lower_flag_r;
    logic [NUM_CHAN-1:0] chan_critical_flag_r;
    logic [NUM_CHAN-1:0] chan_upper_flag_nxt;
    logic [NUM_CHAN-1:0] chan_lower_flag_nxt;
    logic [NUM_CHAN-1:0] chan_critical_flag_nxt;

    // Qualifier outputs, one bit per channel.
    logic [NUM_CHAN-1:0] hi_set;
    logic [NUM_CHAN-1:0] lo_set;
    logic [NUM_CHAN-1:0] crit_set;
    logic [NUM_CHAN-1:0] crit_clr;
    logic [NUM_CHAN-1:0] hi_cond;
    logic [NUM_CHAN-1:0] lo_cond;

    // Hottest-of results.
    logic [7:0] hot_high;
    logic [7:0] hot_low;
    logic [7:0] hot_flags;

    // Counts decoded once here and shared by every channel qualifier.
    wire [2:0] alert_need;
    wire [2:0] crit_need;
    assign alert_need = tlsh_consec_need(alert_consec_count,
                                         ALERT_FALLBACK);
    assign crit_need = tlsh_consec_need(critical_consec_count,
                                        CRIT_FALLBACK);

    // Register port decode. Reads and writes are single-cycle strobes.
    wire rd_upper;
    wire rd_lower;
    wire rd_crit;
    wire rd_hot_high;
    wire rd_hot_low;
    wire rd_hot_flags;
    assign rd_upper = reg_req.addr == ADDR_UPPER;
    assign rd_lower = reg_req.addr == ADDR_LOWER;
    assign rd_crit = reg_req.addr == ADDR_CRIT;
    assign rd_hot_high = reg_req.addr == ADDR_HOT_HIGH;
    assign rd_hot_low = reg_req.addr == ADDR_HOT_LOW;
    assign rd_hot_flags = reg_req.addr == ADDR_HOT_FLAGS;

    // The clearing read pulses that act on the two read-clear registers.
    wire clr_upper_rd;
    wire clr_lower_rd;
    assign clr_upper_rd = reg_req.rd && rd_upper;
    assign clr_lower_rd = reg_req.rd && rd_lower;

    // One-hot dispatch of a measurement to its channel.
    wire [NUM_CHAN-1:0] meas_fire;

    // Beta register hits and their read images.
    wire [NUM_BETA-1:0] beta_hit;
    wire [NUM_BETA-1:0][7:0] beta_image;

    genvar g;

    // One qualifier per channel; each keeps its own queues, so a count
    // change reaches an idle channel at once and a busy one later.
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            assign meas_fire[g] = meas.valid && meas.chan == 3'(g);
            tlsh_chan_qual u_qual (
                .clk(clk),
                .rst(rst),
                .fire(meas_fire[g]),
                .meas(meas),
                .alert_need(alert_need),
                .crit_need(crit_need),
                .hi_set(hi_set[g]),
                .lo_set(lo_set[g]),
                .crit_set(crit_set[g]),
                .crit_clr(crit_clr[g]),
                .hi_cond_r(hi_cond[g]),
                .lo_cond_r(lo_cond[g])
            );
        end
    endgenerate

    // Beta registers for the four external pin pairs. The first one is
    // read-only, so its autodetect bit stays at the reset value.
    generate
        for (g = 0; g < NUM_BETA; g++) begin : g_beta
            wire wr_auto;
            wire start_hit;
            assign beta_hit[g] = reg_req.addr == BETA_ADDR[g];
            assign wr_auto = reg_req.wr && beta_hit[g] && BETA_WRITABLE[g];
            assign start_hit = conv_start && conv_beta_idx == 2'(g);
            assign beta_image[g] = {4'h0, beta_autodetect_en_r[g],
                                    beta_setting_r[g]};

            // Only the autodetect bit takes writes; the setting field is
            // driven by the detector alone so it always shows what is used.
            always_ff @(posedge clk) begin
                if (rst) begin
                    beta_autodetect_en_r[g] <= BETA_RST[g][BETA_AUTO_BIT];
                    beta_setting_r[g] <= BETA_RST[g][2:0];
                end else begin
                    if (wr_auto) begin
                        beta_autodetect_en_r[g] <=
                            reg_req.wdata[BETA_AUTO_BIT];
                    end
                    if (start_hit && beta_autodetect_en_r[g]) begin
                        beta_setting_r[g] <= beta_detect[g];
                    end
                end
            end

            // The applied setting follows the field; with autodetect off
            // the field is frozen, so every conversion uses the same code.
            // Code seven turns the compensation off in the front end.
            always_ff @(posedge clk) begin
                if (rst) begin
                    beta_apply_r[g] <= BETA_RST[g][2:0];
                end else begin
                    beta_apply_r[g] <= beta_setting_r[g];
                end
            end
        end
    endgenerate

    // Hottest-of comparison over the channels picked by the selection.
    tlsh_hottest u_hottest (
        .clk(clk),
        .rst(rst),
        .meas(meas),
        .cycle_done(cycle_done),
        .sel(hottest_sel),
        .hot_high_r(hot_high),
        .hot_low_r(hot_low),
        .hot_flags_r(hot_flags)
    );

    // Next state of the high and low flags. A read clears only the bits
    // whose condition has gone, and a set in the same cycle wins, so an
    // event that lands on the clearing read is never lost.
    assign chan_upper_flag_nxt =
        (chan_upper_flag_r & ~({NUM_CHAN{clr_upper_rd}} & ~hi_cond))
        | hi_set;
    assign chan_lower_flag_nxt =
        (chan_lower_flag_r & ~({NUM_CHAN{clr_lower_rd}} & ~lo_cond))
        | lo_set;

    // Critical flags ignore reads and clear themselves on hysteresis.
    assign chan_critical_flag_nxt =
        (chan_critical_flag_r & ~crit_clr)
        | crit_set;

    // Status flag registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_upper_flag_r <= RST_FLAGS;
            chan_lower_flag_r <= RST_FLAGS;
            chan_critical_flag_r <= RST_FLAGS;
        end else begin
            chan_upper_flag_r <= chan_upper_flag_nxt;
            chan_lower_flag_r <= chan_lower_flag_nxt;
            chan_critical_flag_r <= chan_critical_flag_nxt;
        end
    end

    // Summary flags track the per-channel bits. A read that clears every
    // gone bit clears the summary too, while a bit held by a standing
    // condition keeps the summary up, which software sees on the next poll.
    always_ff @(posedge clk) begin
        if (rst) begin
            summary_r <= '0;
        end else begin
            summary_r.high <= |chan_upper_flag_nxt;
            summary_r.low <= |chan_lower_flag_nxt;
            summary_r.crit <= |chan_critical_flag_nxt;
        end
    end

    // Alert pin is active low and not masked here; masking, if wanted,
    // belongs to the pin driver so that status stays visible regardless.
    always_ff @(posedge clk) begin
        if (rst) begin
            alert_n_r <= 1'b1;
        end else begin
            alert_n_r <= ~(|chan_upper_flag_nxt
                           | |chan_lower_flag_nxt);
        end
    end

    // Read data selection. Status reads return the value before any
    // clearing that the same read causes. Unknown addresses read zero.
    wire [7:0] rd_beta;
    wire [7:0] rd_data;
    assign rd_beta = beta_hit[0] ? beta_image[0] :
                     beta_hit[1] ? beta_image[1] :
                     beta_hit[2] ? beta_image[2] :
                     beta_hit[3] ? beta_image[3] : 8'h00;
    assign rd_data = rd_upper ? chan_upper_flag_r :
                     rd_lower ? chan_lower_flag_r :
                     rd_crit ? chan_critical_flag_r :
                     rd_hot_high ? hot_high :
                     rd_hot_low ? hot_low :
                     rd_hot_flags ? hot_flags : rd_beta;

    // Read data register, loaded on each read strobe and held after.
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_req.rd) begin
            reg_rdata_r <= rd_data;
        end
    end
endmodule

// ===== tb/tlsh_top_monitor.sv
// Checker for the limit status, beta and hottest-of block.
// Assumes it is bound to tlsh_top and sees only that module's ports.
`timescale 1ns/1ps
module tlsh_top_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire tlsh_pkg::tlsh_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_r,
    input wire tlsh_pkg::tlsh_meas_t meas,
    input wire logic conv_start,
    input wire logic [1:0] conv_beta_idx,
    input wire logic [tlsh_pkg::NUM_BETA-1:0][2:0] beta_detect,
    input wire logic cycle_done,
    input wire logic [7:0] hottest_sel,
    input wire logic [2:0] alert_consec_count,
    input wire logic [tlsh_pkg::NUM_BETA-1:0][2:0] beta_apply_r,
    input wire tlsh_pkg::tlsh_summary_t summary_r,
    input wire logic alert_n_r
);
    import tlsh_pkg::*;
    logic none_r;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Tracks whether the last compare had no channel selected.
    always_ff @(posedge clk) begin
        if (rst) begin
            none_r <= 1'b1;
        end else if (cycle_done) begin
            none_r <= (hottest_sel == 8'h00);
        end
    end
    // A read in the compare cycle is skipped, as the result moves then.
    hot_none_a: assert property (reg_req.rd && !cycle_done &&
        none_r && reg_req.addr == ADDR_HOT_HIGH
        |=> reg_rdata_r == RST_HOT_HIGH)
        else $error("hottest high byte not 80h with nothing selected");
    alert_follows_a: assert property (
        alert_n_r == !(summary_r.high || summary_r.low))
        else $error("alert does not follow high and low flags");
    high_rise_a: assert property ($rose(summary_r.high) |->
        $past(meas.valid) && $past(meas.hi_ge))
        else $error("high flag rose without a high measurement");
    low_rise_a: assert property ($rose(summary_r.low) |->
        $past(meas.valid) && $past(meas.lo_lt))
        else $error("low flag rose without a low measurement");
    crit_rise_a: assert property ($rose(summary_r.crit) |->
        $past(meas.valid) && $past(meas.crit_ge))
        else $error("critical flag rose without a critical measurement");
    high_hold_a: assert property (summary_r.high &&
        !(reg_req.rd && reg_req.addr == ADDR_UPPER) |=> summary_r.high)
        else $error("high flag dropped without a status read");
    low_hold_a: assert property (summary_r.low &&
        !(reg_req.rd && reg_req.addr == ADDR_LOWER) |=> summary_r.low)
        else $error("low flag dropped without a status read");
    crit_hold_a: assert property (summary_r.crit &&
        !(meas.valid && meas.crit_below_hyst) |=> summary_r.crit)
        else $error("critical flag dropped above the hysteresis band");
    low_once_a: assert property (alert_consec_count == 3'h2 &&
        meas.valid && meas.lo_lt |=> summary_r.low)
        else $error("fallback alert count is not one");
    beta_use_a: assert property (conv_start && conv_beta_idx == 2'h0
        |-> ##2 beta_apply_r[0] == $past(beta_detect[0], 2))
        else $error("detected beta not applied");
    cover property (summary_r.high);
    cover property (summary_r.crit);
    cover property (conv_start && conv_beta_idx == 2'h3);
endmodule

// ===== tb/tlsh_host.sv
// Register host model issuing one-cycle read and write strobes.
// Assumes the device takes a strobe at a rising edge and answers next.
`timescale 1ns/1ps
module tlsh_host (
    input wire logic clk,
    output tlsh_pkg::tlsh_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_r
);
    import tlsh_pkg::*;
    initial reg_req = '0;
    // Released address and data are inverted so stale values never match.
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        reg_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
        q = reg_rdata_r;
    endtask
endmodule

// ===== tb/tlsh_top_tb.sv
// Self-checking bench for the limit status and hottest-of block.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ps
module tlsh_top_tb;
    import tlsh_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tlsh_reg_req_t reg_req;
    logic [7:0] reg_rdata_r;
    tlsh_meas_t meas = '0;
    logic conv_start = 1'b0;
    logic [1:0] conv_beta_idx = 2'h0;
    logic [NUM_BETA-1:0][2:0] beta_detect = '0;
    logic cycle_done = 1'b0;
    logic [7:0] hottest_sel = 8'h00;
    logic [2:0] alert_consec_count = 3'h1;
    logic [2:0] critical_consec_count = 3'h5;
    logic [NUM_BETA-1:0][2:0] beta_apply_r;
    tlsh_summary_t summary_r;
    logic alert_n_r;
    logic [7:0] q;
    int failures = 0;
    int check_count = 0;
    tlsh_top i_dut (.clk, .rst, .reg_req, .reg_rdata_r, .meas, .conv_start,
        .conv_beta_idx, .beta_detect, .cycle_done, .hottest_sel,
        .alert_consec_count, .critical_consec_count, .beta_apply_r,
        .summary_r, .alert_n_r);
    tlsh_host i_host (.clk, .reg_req, .reg_rdata_r);
    always #5 clk = ~clk;
    // Comparison and bus helpers; chk and rd serve every scenario, wr only t_beta.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, q);
    endtask
    // Flags are high, low, critical, below-hysteresis from bit 3 down.
    task automatic ms(input logic [2:0] c, input logic [3:0] f,
                      input logic [10:0] t);
        @(posedge clk);
        meas <= {1'b1, c, t, f};
        @(posedge clk);
        meas <= {1'b0, ~c, ~t, ~f};
        #1;
    endtask
    task automatic hot(input logic [7:0] s);
        @(posedge clk);
        hottest_sel <= s;
        cycle_done <= 1'b1;
        @(posedge clk);
        cycle_done <= 1'b0;
        #1;
    endtask
    task automatic conv(input logic [1:0] i, input logic [2:0] d);
        @(posedge clk);
        conv_start <= 1'b1;
        conv_beta_idx <= i;
        beta_detect[i] <= d;
        @(posedge clk);
        conv_start <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        logic [7:0] a [11] = '{8'h25, 8'h26, 8'h71, 8'h72, 8'h32, 8'h33,
                               8'h34, 8'h35, 8'h36, 8'h37, 8'h50};
        logic [7:0] e [11] = '{8'h08, 8'h08, 8'h08, 8'h07, 8'h80, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        chk({6'h00, summary_r.high, alert_n_r}, 8'h01);
        for (int i = 0; i < 11; i++) begin
            rd(a[i], e[i]);
        end
    endtask
    // Autodetect off keeps the stored code; writes never reach the field.
    task automatic t_beta();
        wr(8'h25, 8'h00);
        rd(8'h25, 8'h08);
        wr(8'h26, 8'h07);
        rd(8'h26, 8'h00);
        conv(2'h1, 3'h5);
        rd(8'h26, 8'h00);
        chk({5'h00, beta_apply_r[1]}, 8'h00);
        conv(2'h0, 3'h6);
        rd(8'h25, 8'h0e);
        chk({5'h00, beta_apply_r[0]}, 8'h06);
        chk({5'h00, beta_apply_r[3]}, 8'h07);
        wr(8'h72, 8'h0f);
        conv(2'h3, 3'h2);
        rd(8'h72, 8'h0a);
        wr(8'h71, 8'hf7);
        rd(8'h71, 8'h00);
        conv(2'h2, 3'h4);
        chk({5'h00, beta_apply_r[2]}, 8'h00);
    endtask
    // Listed codes: alert 111 needs four in a row, critical 000 needs one.
    task automatic t_codes();
        @(posedge clk);
        alert_consec_count <= 3'h7;
        critical_consec_count <= 3'h0;
        for (int i = 0; i < 3; i++) begin
            ms(3'h6, 4'h8, 11'h000);
        end
        rd(8'h35, 8'h00);
        ms(3'h6, 4'h8, 11'h000);
        rd(8'h35, 8'h40);
        ms(3'h4, 4'h2, 11'h000);
        rd(8'h37, 8'h10);
        ms(3'h4, 4'h1, 11'h000);
        ms(3'h6, 4'h0, 11'h000);
        rd(8'h35, 8'h40);
        rd(8'h35, 8'h00);
        chk({5'h00, summary_r.high, summary_r.crit, alert_n_r}, 8'h01);
    endtask
    // Count of two: a broken run must not set the flag.
    task automatic t_high();
        ms(3'h1, 4'h8, 11'h000);
        ms(3'h1, 4'h0, 11'h000);
        ms(3'h1, 4'h8, 11'h000);
        rd(8'h35, 8'h00);
        ms(3'h1, 4'h8, 11'h000);
        chk({6'h00, summary_r.high, alert_n_r}, 8'h02);
        rd(8'h35, 8'h02);
        rd(8'h35, 8'h02);
        ms(3'h1, 4'h0, 11'h000);
        rd(8'h35, 8'h02);
        chk({6'h00, summary_r.high, alert_n_r}, 8'h01);
        rd(8'h35, 8'h00);
    endtask
    // Unlisted alert code falls back to a count of one.
    task automatic t_low();
        @(posedge clk);
        alert_consec_count <= 3'h2;
        ms(3'h0, 4'h4, 11'h000);
        chk({6'h00, summary_r.low, alert_n_r}, 8'h02);
        rd(8'h36, 8'h01);
        ms(3'h0, 4'h0, 11'h000);
        rd(8'h36, 8'h01);
        chk({6'h00, summary_r.low, alert_n_r}, 8'h01);
        rd(8'h36, 8'h00);
    endtask
    // Unlisted critical code falls back to four; reads never clear.
    task automatic t_crit();
        for (int i = 0; i < 3; i++) begin
            ms(3'h2, 4'h2, 11'h000);
        end
        rd(8'h37, 8'h00);
        ms(3'h2, 4'h2, 11'h000);
        rd(8'h37, 8'h04);
        chk({7'h00, summary_r.crit}, 8'h01);
        rd(8'h37, 8'h04);
        for (int i = 0; i < 4; i++) begin
            ms(3'h3, 4'h2, 11'h000);
        end
        ms(3'h2, 4'h0, 11'h000);
        rd(8'h37, 8'h0c);
        ms(3'h2, 4'h1, 11'h000);
        rd(8'h37, 8'h08);
        chk({7'h00, summary_r.crit}, 8'h01);
        ms(3'h3, 4'h1, 11'h000);
        chk({7'h00, summary_r.crit}, 8'h00);
    endtask
    // Tie, unselected hotter channel, fraction and sign.
    task automatic t_hot();
        hot(8'h00);
        rd(8'h32, 8'h80);
        rd(8'h34, 8'h00);
        ms(3'h0, 4'h0, 11'h0c8);
        ms(3'h1, 4'h0, 11'h0c8);
        ms(3'h5, 4'h0, 11'h0d5);
        ms(3'h7, 4'h0, 11'h7f8);
        hot(8'h03);
        rd(8'h34, 8'h01);
        rd(8'h32, 8'h19);
        hot(8'h22);
        rd(8'h32, 8'h1a);
        rd(8'h33, 8'ha0);
        rd(8'h34, 8'h20);
        hot(8'h80);
        rd(8'h32, 8'hff);
        rd(8'h34, 8'h80);
    endtask
    task automatic summarize();
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // The whole run needs well under a thousand cycles.
    initial begin
        #50000;
        failures++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_beta();
        t_high();
        t_low();
        t_crit();
        t_codes();
        t_hot();
        summarize();
    end
endmodule
bind tlsh_top tlsh_top_monitor i_mon (.clk, .rst, .reg_req, .reg_rdata_r,
    .meas, .conv_start, .conv_beta_idx, .beta_detect, .cycle_done,
    .hottest_sel, .alert_consec_count, .beta_apply_r, .summary_r,
    .alert_n_r);
